/* File: frt_timer.sv */
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - width select n gives n+1 counter bits
// - width select at [12:8], resets 32-bit
// - count clock is input over divider+1
// - start bit runs timer, resets running
// - counter steps downward once per tick
// - count equals active compare raises match
// - staging copied to active on start/match/wrap
// - wrap raises event, counting restarts
// - count and active compare readable
// - clock gate bit enables counting, resets 1
// - debug halt freezes timer in debug
// - soft reset bit one resets timer
// - reset status set during soft reset
// - mask bit0 wrap, bit2 match, wrap on
// - read-only 26-bit identity field
// - raw status bit0 wrap, bit2 match
// - masked status is mask and raw
// - clear bit one clears matching flag
// - narrow counts read zero upper bits
module frt_timer
  import frt_pkg::*;
#(
  parameter int          COUNT_BITS = 32,
  parameter logic [25:0] IDENTITY   = DEF_IDENTITY
)(
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  input  wire logic        i_debug_mode,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic             o_match_pulse,
  output logic             o_wrap_pulse
);

  // ****************************************
  // debug input synchroniser
  // ****************************************
  logic dbg_meta;
  logic dbg_sync;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      dbg_meta <= 1'b0;
      dbg_sync <= 1'b0;
    end else begin
      dbg_meta <= i_debug_mode;
      dbg_sync <= dbg_meta;
    end
  end

  // ****************************************
  // bus address phase capture
  // ****************************************
  logic        wr_pend;
  logic        rd_pend;
  logic [11:0] addr_q;

  wire addr_take = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ || i_htrans == HTRANS_SEQ);

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q  <= 12'h000;
    end else if (i_hready) begin
      wr_pend <= addr_take && i_hwrite;
      rd_pend <= addr_take && !i_hwrite;
      addr_q  <= {i_haddr[11:2], 2'b00};
    end
  end

  wire wr_ctl   = wr_pend && (addr_q == OFS_TIMER_CONTROL);
  wire wr_gate  = wr_pend && (addr_q == OFS_CLOCK_ENABLE_CTL);
  wire wr_srst  = wr_pend && (addr_q == OFS_SOFT_RESET_TRIG) && i_hwdata[POS_SOFT_RESET];
  wire wr_mask  = wr_pend && (addr_q == OFS_INT_ENABLE_MASK);
  wire wr_clr   = wr_pend && (addr_q == OFS_EVENT_CLEAR);
  wire wr_stage = wr_pend && (addr_q == OFS_CMP_STAGING);

  // ****************************************
  // software registers
  // ****************************************
  logic        run_bit;
  logic [4:0]  width_sel;
  logic [15:0] divisor;
  logic        clock_gate;
  logic        debug_halt;
  logic        wrap_ena;
  logic        match_ena;
  logic [31:0] staging;
  logic [1:0]  srst_cnt;
  logic        srst_busy;

  wire soft_clear = srst_busy;

  // soft reset holds the timer in default state for a few cycles
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      srst_cnt  <= 2'h0;
      srst_busy <= 1'b0;
    end else if (wr_srst) begin
      srst_cnt  <= SOFT_RESET_CYCLES;
      srst_busy <= 1'b1;
    end else if (srst_cnt != 2'h0) begin
      srst_cnt  <= srst_cnt - 2'h1;
      srst_busy <= (srst_cnt != 2'h1);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      run_bit   <= RST_START;
      width_sel <= RST_WIDTH_SEL;
      divisor   <= RST_DIVIDER;
    end else if (soft_clear) begin
      run_bit   <= RST_START;
      width_sel <= RST_WIDTH_SEL;
      divisor   <= RST_DIVIDER;
    end else if (wr_ctl) begin
      run_bit   <= i_hwdata[POS_START];
      width_sel <= i_hwdata[POS_WIDTH_HI:POS_WIDTH_LO];
      divisor   <= i_hwdata[POS_DIV_HI:POS_DIV_LO];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      clock_gate <= RST_CLOCK_GATE;
      debug_halt <= RST_DEBUG_HALT;
      wrap_ena   <= RST_WRAP_ENA;
      match_ena  <= RST_MATCH_ENA;
      staging    <= RST_WORD;
    end else if (soft_clear) begin
      clock_gate <= RST_CLOCK_GATE;
      debug_halt <= RST_DEBUG_HALT;
      wrap_ena   <= RST_WRAP_ENA;
      match_ena  <= RST_MATCH_ENA;
      staging    <= RST_WORD;
    end else begin
      if (wr_gate) begin
        clock_gate <= i_hwdata[POS_CLOCK_GATE];
        debug_halt <= i_hwdata[POS_DEBUG_HALT];
      end
      if (wr_mask) begin
        wrap_ena  <= i_hwdata[POS_WRAP_EVENT];
        match_ena <= i_hwdata[POS_MATCH_EVENT];
      end
      if (wr_stage) begin
        staging <= i_hwdata;
      end
    end
  end

  // ****************************************
  // count clock divider
  // ****************************************
  frt_tick_if tick_bus ();

  // gate, debug freeze and stop all hold the count
  wire counting_ok = run_bit && clock_gate && !(debug_halt && dbg_sync) && !soft_clear;

  assign tick_bus.clear   = soft_clear;
  assign tick_bus.enable  = counting_ok;
  assign tick_bus.divisor = divisor;

  frt_divider u_divider (
    .i_mclk   (i_mclk),
    .i_rstn   (i_rstn),
    .tick_bus (tick_bus)
  );

  // ****************************************
  // counter core
  // ****************************************
  logic [COUNT_BITS-1:0] count;
  logic [31:0]           active;
  logic                  run_prev;
  logic                  raw_wrap;
  logic                  raw_match;

  // mask of valid counter bits from width select
  wire [31:0] width_mask = 32'hFFFF_FFFF >> (5'd31 - width_sel);
  wire [31:0] count_ext  = 32'(count);
  wire [31:0] count_word = count_ext & width_mask;
  wire        step       = tick_bus.tick && counting_ok;
  wire        at_zero    = (count_word == 32'h0000_0000);
  wire [31:0] next_down  = (count_word - 32'h0000_0001) & width_mask;
  wire        hit_match  = step && (count_word == (active & width_mask));
  wire        hit_wrap   = step && at_zero;
  wire        start_edge = run_bit && !run_prev;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      count    <= '0;
      run_prev <= 1'b0;
    end else if (soft_clear) begin
      count    <= '0;
      run_prev <= 1'b0;
    end else begin
      run_prev <= run_bit;
      if (step) begin
        count <= next_down[COUNT_BITS-1:0];
      end
    end
  end

  // buffer reload on start, match and wrap
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      active <= RST_WORD;
    end else if (soft_clear) begin
      active <= RST_WORD;
    end else if (start_edge || hit_match || hit_wrap) begin
      active <= staging;
    end
  end

  // ****************************************
  // event flags: set wins over clear
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      raw_wrap      <= 1'b0;
      raw_match     <= 1'b0;
      o_wrap_pulse  <= 1'b0;
      o_match_pulse <= 1'b0;
    end else if (soft_clear) begin
      raw_wrap      <= 1'b0;
      raw_match     <= 1'b0;
      o_wrap_pulse  <= 1'b0;
      o_match_pulse <= 1'b0;
    end else begin
      raw_wrap      <= hit_wrap || (raw_wrap && !(wr_clr && i_hwdata[POS_WRAP_EVENT]));
      raw_match     <= hit_match || (raw_match && !(wr_clr && i_hwdata[POS_MATCH_EVENT]));
      o_wrap_pulse  <= hit_wrap;
      o_match_pulse <= hit_match;
    end
  end

  // ****************************************
  // read data mux
  // ****************************************
  wire [31:0] ev_raw    = {29'h0, raw_match, 1'b0, raw_wrap};
  wire [31:0] ev_mask   = {29'h0, match_ena, 1'b0, wrap_ena};
  wire [31:0] ev_masked = ev_raw & ev_mask;

  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (i_haddr[11:0] & 12'hFFC)
      OFS_BLOCK_IDENTITY:   next_rdata = {6'h00, IDENTITY};
      OFS_CLOCK_ENABLE_CTL: next_rdata = {debug_halt, 30'h0, clock_gate};
      OFS_TIMER_CONTROL:    next_rdata = {divisor, 3'h0, width_sel, 7'h00, run_bit};
      OFS_TIMER_STATUS:     next_rdata = {31'h0, srst_busy};
      OFS_INT_ENABLE_MASK:  next_rdata = ev_mask;
      OFS_RAW_EVENT_STATUS: next_rdata = ev_raw;
      OFS_MASKED_EVENT_ST:  next_rdata = ev_masked;
      OFS_CMP_STAGING:      next_rdata = staging;
      OFS_CMP_ACTIVE:       next_rdata = active;
      OFS_CURRENT_COUNT:    next_rdata = count_word;
      default:              next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      if (addr_take && !i_hwrite) begin
        o_hrdata <= next_rdata;
      end
    end
  end

endmodule
`default_nettype wire

/* File: frt_pkg.sv */
package frt_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [11:0] OFS_BLOCK_IDENTITY   = 12'h000;
  localparam logic [11:0] OFS_CLOCK_ENABLE_CTL = 12'h004;
  localparam logic [11:0] OFS_SOFT_RESET_TRIG  = 12'h008;
  localparam logic [11:0] OFS_TIMER_CONTROL    = 12'h00C;
  localparam logic [11:0] OFS_TIMER_STATUS     = 12'h010;
  localparam logic [11:0] OFS_INT_ENABLE_MASK  = 12'h014;
  localparam logic [11:0] OFS_RAW_EVENT_STATUS = 12'h018;
  localparam logic [11:0] OFS_MASKED_EVENT_ST  = 12'h01C;
  localparam logic [11:0] OFS_EVENT_CLEAR      = 12'h020;
  localparam logic [11:0] OFS_CMP_STAGING      = 12'h024;
  localparam logic [11:0] OFS_CMP_ACTIVE       = 12'h028;
  localparam logic [11:0] OFS_CURRENT_COUNT    = 12'h02C;

  // ****************************************
  // field positions
  // ****************************************
  localparam int POS_START       = 0;
  localparam int POS_WIDTH_LO    = 8;
  localparam int POS_WIDTH_HI    = 12;
  localparam int POS_DIV_LO      = 16;
  localparam int POS_DIV_HI      = 31;
  localparam int POS_CLOCK_GATE  = 0;
  localparam int POS_DEBUG_HALT  = 31;
  localparam int POS_SOFT_RESET  = 0;
  localparam int POS_WRAP_EVENT  = 0;
  localparam int POS_MATCH_EVENT = 2;
  localparam int IDENTITY_BITS   = 26;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic        RST_START       = 1'h1;
  localparam logic [4:0]  RST_WIDTH_SEL   = 5'h1F;
  localparam logic [15:0] RST_DIVIDER     = 16'h0000;
  localparam logic        RST_CLOCK_GATE  = 1'h1;
  localparam logic        RST_DEBUG_HALT  = 1'h0;
  localparam logic        RST_WRAP_ENA    = 1'h1;
  localparam logic        RST_MATCH_ENA   = 1'h0;
  localparam logic [31:0] RST_WORD        = 32'h0000_0000;
  // identity value is arbitrary
  localparam logic [25:0] DEF_IDENTITY    = 26'h0A5_5A01;

  // soft reset sequencing: cycles the status bit stays set
  localparam logic [1:0]  SOFT_RESET_CYCLES = 2'h2;

  // ****************************************
  // bus transfer types
  // ****************************************
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ    = 2'h3;

endpackage

/* File: frt_tick_if.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// count-clock tick between divider and core
// ****************************************
interface frt_tick_if;
  logic        clear;
  logic        enable;
  logic [15:0] divisor;
  logic        tick;
  modport src (input clear, input enable, input divisor, output tick);
  modport dst (output clear, output enable, output divisor, input tick);
endinterface
`default_nettype wire

/* File: frt_divider.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// count clock divider: one pulse every divisor+1 enabled cycles
// ****************************************
module frt_divider
  import frt_pkg::*;
(
  input  wire logic  i_mclk,
  input  wire logic  i_rstn,
  frt_tick_if.src    tick_bus
);

  logic [15:0] div_count;
  wire         div_end = (div_count >= tick_bus.divisor);

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_count     <= 16'h0000;
      tick_bus.tick <= 1'b0;
    end else if (tick_bus.clear || !tick_bus.enable) begin
      div_count     <= 16'h0000;
      tick_bus.tick <= 1'b0;
    end else begin
      div_count     <= div_end ? 16'h0000 : div_count + 16'h0001;
      tick_bus.tick <= div_end;
    end
  end

endmodule
`default_nettype wire

/* File: frt_timer_checker.sv */
`timescale 1ns/1ns
`default_nettype none
// ********
// bus and event checks
// ********
module frt_timer_checker
  import frt_pkg::*;
#(
  parameter logic [25:0] IDENTITY = DEF_IDENTITY
)(
  input wire logic        i_mclk,
  input wire logic        i_rstn,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic [2:0]  i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic        i_hready,
  input wire logic        i_debug_mode,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic        o_match_pulse,
  input wire logic        o_wrap_pulse
);
  logic       rd_req;
  logic       wr_req;
  logic       wr_ph;
  logic [9:0] wr_idx;
  logic       run_sh;
  logic       gate_sh;
  logic       stopped;
  assign rd_req  = i_hsel && i_hready && i_htrans[1] && !i_hwrite;
  assign wr_req  = i_hsel && i_hready && i_htrans[1] && i_hwrite;
  assign stopped = !run_sh || !gate_sh;
  // shadow of start and gate bits, taken from write data phases
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ph   <= 1'b0;
      wr_idx  <= 10'h000;
      run_sh  <= RST_START;
      gate_sh <= RST_CLOCK_GATE;
    end else begin
      wr_ph  <= wr_req;
      wr_idx <= i_haddr[11:2];
      if (wr_ph && wr_idx == 10'h003) begin
        run_sh <= i_hwdata[0];
      end
      if (wr_ph && wr_idx == 10'h001) begin
        gate_sh <= i_hwdata[0];
      end
      if (wr_ph && wr_idx == 10'h002 && i_hwdata[0]) begin
        run_sh  <= 1'b1;
        gate_sh <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);
  ready_high_a: assert property (o_hreadyout)
    else $error("hreadyout low");
  resp_okay_a: assert property (!o_hresp)
    else $error("hresp not okay");
  match_pulse_a: assert property (o_match_pulse |=> !o_match_pulse)
    else $error("match pulse too long");
  wrap_pulse_a: assert property (o_wrap_pulse |=> !o_wrap_pulse)
    else $error("wrap pulse too long");
  id_read_a: assert property (rd_req && i_haddr[11:2] == 10'h000 |=> o_hrdata == {6'h00, IDENTITY})
    else $error("identity read wrong");
  unmapped_zero_a: assert property (rd_req && i_haddr[11:2] > 10'h00B |=> o_hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  flag_reserved_a: assert property (rd_req && i_haddr[11:2] inside {[10'h005:10'h008]}
    |=> o_hrdata[31:3] == 29'h0000_0000 && !o_hrdata[1])
    else $error("flag register reserved bits set");
  stopped_quiet_a: assert property (stopped [*4] |-> !o_match_pulse && !o_wrap_pulse)
    else $error("event while stopped");
endmodule
bind frt_timer frt_timer_checker #(.IDENTITY(IDENTITY)) u_frt_timer_checker (
  .i_mclk(i_mclk), .i_rstn(i_rstn), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(i_hready),
  .i_debug_mode(i_debug_mode), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_match_pulse(o_match_pulse), .o_wrap_pulse(o_wrap_pulse));
`default_nettype wire

/* File: frt_timer_test.sv */
`timescale 1ns/1ns
`default_nettype none
// ********
// register-level bench
// ********
module frt_timer_test
  import frt_pkg::*;
;
  logic        i_mclk;
  logic        i_rstn;
  logic        i_hsel;
  logic [31:0] i_haddr;
  logic [1:0]  i_htrans;
  logic        i_hwrite;
  logic [2:0]  i_hsize;
  logic [31:0] i_hwdata;
  logic        i_hready;
  logic        i_debug_mode;
  logic [31:0] o_hrdata;
  logic        o_hreadyout;
  logic        o_hresp;
  logic        o_match_pulse;
  logic        o_wrap_pulse;
  int          fails;
  int          num_checks;
  logic [31:0] q;
  logic [31:0] c0;
  int          n;
  logic [11:0] ofs [10] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h020, 12'h024, 12'h028, 12'h030};
  logic [31:0] rv [10] = '{{6'h00, DEF_IDENTITY}, 32'h1, 32'h0, 32'h1F01, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
  assign i_hready = o_hreadyout;
  always #10 i_mclk = ~i_mclk;
  frt_timer u_frt_timer (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(i_hready),
    .i_debug_mode(i_debug_mode), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_match_pulse(o_match_pulse), .o_wrap_pulse(o_wrap_pulse));
  task automatic stop_test();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // wait for a pulse or hready, bounded
  task automatic wait_sig(input int sel, input int lim, output int k);
    k = 0;
    do begin
      @(posedge i_mclk);
      k++;
    end while ((sel == 0 ? o_hreadyout : sel == 1 ? o_wrap_pulse : o_match_pulse) !== 1'b1 && k < lim);
    if (k >= lim) begin
      fails++;
      stop_test();
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    i_haddr  <= {20'h00000, a};
    i_htrans <= HTRANS_NONSEQ;
    i_hwrite <= w;
    wait_sig(0, 50, k);
    i_htrans <= 2'h0;
    i_hwdata <= d;
    wait_sig(0, 50, k);
    q = o_hrdata;
  endtask
  task automatic rd(input string name, input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(name, q, exp);
  endtask
  initial begin
    {i_mclk, i_rstn, i_hwrite, i_debug_mode} = 4'h0;
    {i_haddr, i_hwdata, i_htrans} = 66'h0;
    i_hsel = 1'b1;
    i_hsize = 3'h2;
    fails = 0;
    num_checks = 0;
    repeat (5) @(posedge i_mclk);
    i_rstn <= 1'b1;
    @(posedge i_mclk);
    for (int i = 0; i < 10; i++) begin
      rd("reset value", ofs[i], rv[i]);
    end
    xfer(1'b1, 12'h000, 32'hFFFF_FFFF);
    rd("identity", 12'h000, {6'h00, DEF_IDENTITY});
    xfer(1'b1, 12'h00C, 32'h0003_E7FE);
    rd("control", 12'h00C, 32'h0003_0700);
    xfer(1'b1, 12'h020, 32'h5);
    rd("raw cleared", 12'h018, 32'h0);
    xfer(1'b0, 12'h02C, 32'h0);
    c0 = q;
    rd("held count", 12'h02C, c0);
    xfer(1'b1, 12'h024, 32'h20);
    xfer(1'b1, 12'h014, 32'h5);
    xfer(1'b1, 12'h00C, 32'h0003_0701);
    @(posedge i_mclk);
    rd("active on start", 12'h028, 32'h20);
    wait_sig(1, 4000, n);
    wait_sig(1, 4000, n);
    check("wrap period", n, 32'd1024);
    rd("raw flags", 12'h018, 32'h5);
    xfer(1'b1, 12'h014, 32'h4);
    rd("masked flags", 12'h01C, 32'h4);
    xfer(1'b1, 12'h020, 32'h1);
    rd("wrap cleared", 12'h018, 32'h4);
    xfer(1'b1, 12'h020, 32'h4);
    rd("match cleared", 12'h018, 32'h0);
    xfer(1'b1, 12'h024, 32'h40);
    rd("active kept", 12'h028, 32'h20);
    wait_sig(2, 4000, n);
    rd("active on match", 12'h028, 32'h40);
    xfer(1'b0, 12'h02C, 32'h0);
    check("narrow count", {8'h00, q[31:8]}, 32'h0);
    xfer(1'b1, 12'h004, 32'h0);
    xfer(1'b0, 12'h02C, 32'h0);
    c0 = q;
    rd("gated count", 12'h02C, c0);
    xfer(1'b1, 12'h004, 32'h8000_0001);
    i_debug_mode <= 1'b1;
    repeat (8) @(posedge i_mclk);
    xfer(1'b0, 12'h02C, 32'h0);
    c0 = q;
    rd("debug halt", 12'h02C, c0);
    i_debug_mode <= 1'b0;
    repeat (8) @(posedge i_mclk);
    xfer(1'b0, 12'h02C, 32'h0);
    check("resumed", {31'h0, q === c0}, 32'h0);
    xfer(1'b1, 12'h008, 32'h0);
    rd("no soft reset", 12'h00C, 32'h0003_0701);
    xfer(1'b1, 12'h008, 32'h1);
    rd("reset busy", 12'h010, 32'h1);
    repeat (4) @(posedge i_mclk);
    rd("reset done", 12'h010, 32'h0);
    rd("control default", 12'h00C, 32'h1F01);
    rd("mask default", 12'h014, 32'h1);
    stop_test();
  end
endmodule
`default_nettype wire
